// ==== hdl/ccg_pkg.sv ====
package ccg_pkg;
	// register byte addresses
	localparam logic [7:0] OSC_CTRL_ADDR  = 8'h00;
	localparam logic [7:0] FREQ_MEAS_ADDR = 8'h04;
	localparam logic [7:0] MUL_CFG_ADDR   = 8'h08;
	localparam logic [7:0] SYS_CLK_ADDR   = 8'h0C;
	localparam logic [7:0] WAKE_MODE_ADDR = 8'h10;
	localparam logic [7:0] PGATE_EN_ADDR  = 8'h14;
	localparam logic [7:0] PGATE_DIS_ADDR = 8'h18;
	localparam logic [7:0] PGATE_ST_ADDR  = 8'h1C;
	localparam logic [7:0] PWR_STAT_ADDR  = 8'h20;
	localparam logic [7:0] TICK_CAL_ADDR  = 8'h24;

	// status, frequency tally and wake mode register bit positions
	localparam int ST_XTAL_STABLE = 0;
	localparam int ST_MUL_READY   = 1;
	localparam int ST_SYS_READY   = 3;
	localparam int ST_SWITCH_DONE = 16;
	localparam int ST_RC_STABLE   = 17;
	localparam int TALLY_DONE_BIT = 16;
	localparam int DEEP_SLEEP_BIT = 20;

	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	localparam logic [31:0] TICK_CAL    = 32'h0000_1770;
	localparam logic [4:0]  TALLY_FALLS = 5'h10;
	localparam logic [7:0]  XTAL_PREDIV = 8'h08;
	localparam logic [7:0]  HALVE_DIV   = 8'h02;
	localparam logic [3:0]  RC_SETTLE   = 4'h4;

	typedef enum logic [1:0] {
		SRC_SLOW,
		SRC_PRIMARY,
		SRC_MUL,
		SRC_MUL_ALT
	} ccg_src_t;

	typedef struct packed {
		logic [7:0] xtal_startup;
		logic [1:0] rc_frequency_select;
		logic       crystal_enable;
		logic       main_osc_select;
	} ccg_osc_ctl_t;

	typedef struct packed {
		logic [10:0] feedback_factor;
		logic [7:0]  settle_count;
		logic [7:0]  input_prescale_value;
	} ccg_mul_cfg_t;

	typedef struct packed {
		logic       halve_multiplied_clock;
		logic [2:0] master_divide_select;
		ccg_src_t   master_source_select;
	} ccg_sys_cfg_t;

	localparam ccg_osc_ctl_t OSC_CTL_RST = '0;
	localparam ccg_mul_cfg_t MUL_CFG_RST = '0;
	localparam ccg_sys_cfg_t SYS_CFG_RST = '{1'b0, 3'h0, SRC_PRIMARY};
endpackage : ccg_pkg

// ==== hdl/ccg_tick_div.sv ====
// divides a stream of one-cycle ticks by a run-time divisor; 0 stops output
module ccg_tick_div #(
	parameter int W = 8
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic         tick_in,
	input  wire logic         restart,
	input  wire logic [W-1:0] divisor,
	output logic              tick_out
);
	logic [W-1:0] cnt_q;

	always_ff @(posedge aclk) begin
		if (!aresetn || restart) begin
			cnt_q    <= '0;
			tick_out <= 1'b0;
		end else if (divisor == '0) begin
			cnt_q    <= '0;
			tick_out <= 1'b0;
		end else if (tick_in) begin
			if (cnt_q >= divisor - W'(1)) begin
				cnt_q    <= '0;
				tick_out <= 1'b1;
			end else begin
				cnt_q    <= cnt_q + W'(1);
				tick_out <= 1'b0;
			end
		end else begin
			tick_out <= 1'b0;
		end
	end
endmodule : ccg_tick_div

// ==== hdl/ccg_top.sv ====
// Contract
// RULE1: primary source changes glitch-free, following main_osc_select.
// RULE2: primary_switch_done_flag rises when the source switch completes.
// RULE3: fast RC is primary source after reset and on Wait mode entry.
// RULE4: tally restarts on next slow rise after stability or selection change; code skips it when the switch completes in its first cycle.
// RULE5: at 16th slow falling edge, tally stops and tally_done_flag sets.
// RULE6: input prescaler 1..255; zero forces divider and multiplied clock low.
// RULE7: multiplied clock rate is source times (feedback_factor+1)/prescale.
// RULE8: feedback_factor zero powers multiplier down; nonzero restarts it.
// RULE9: re-enable or parameter change clears settled flag, loads settle_count.
// RULE10: lock counter decrements per slow cycle; zero sets pll_settled_flag.
// RULE11: software programs enough settle time, waits for settled flag.
// RULE12: halve_multiplied_clock halves multiplied clock before system selector.
// RULE13: software keeps RC/osc selection fixed while system runs off RC-fed multiplier.
// RULE14: software moves system clock to primary around such changes.
// RULE15: master_source_select picks slow, primary or multiplied clock.
// RULE16: master_divide_select divides by 1,2,4,...,64 or by 3.
// RULE17: system clock register write clears ready flag until new clock established.
// RULE18: wait-for-interrupt/event with deep_sleep_select zero stops core clock.
// RULE19: core clock on after reset; restarted by enabled interrupt or reset.
// RULE20: current instruction completes before gating; other masters unaffected.
// RULE21: tick calibration value reads fixed 6000.
// RULE22: peripheral clocks gated individually via enable/disable/status registers.
// RULE23: disabled peripheral clock stops immediately; all disabled after reset.
// RULE24: peripheral gate bit number equals the peripheral identifier.
// RULE25: RC frequency change clears rc_stable_flag, stops primary until stable.
// RULE26: crystal enable clears flag, counts startup on slow/8, sets at zero.
module ccg_top #(
	parameter int N_PERIPH = 32
) (
	input  wire logic                aclk,
	input  wire logic                aresetn,
	input  wire logic [7:0]          s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [7:0]          s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	input  wire logic                low_rate_clock,
	input  wire logic                rc_osc_clock,
	input  wire logic                xtal_osc_clock,
	input  wire logic                wait_mode_entry,
	input  wire logic                sleep_request,
	input  wire logic                instr_done,
	input  wire logic                wake_irq,
	output logic                     primary_clock,
	output logic                     multiplied_clock,
	output logic                     system_clock,
	output logic                     free_core_clock,
	output logic                     core_clock,
	output logic                     core_clock_on,
	output logic [N_PERIPH-1:0]      periph_clock
);
	typedef enum logic [1:0] {
		CORE_RUN,
		CORE_DRAIN,
		CORE_STOP
	} ccg_core_t;

	ccg_pkg::ccg_osc_ctl_t osc_q;
	ccg_pkg::ccg_mul_cfg_t mul_q;
	ccg_pkg::ccg_sys_cfg_t sys_q;
	ccg_core_t             core_q;
	logic [2:0]            sync1_q, sync2_q, sync3_q;
	logic                  slow_rise, slow_fall, rc_tick, xt_tick, xt8_tick;
	logic                  aw_full_q, w_full_q, wr_en, rd_en;
	logic [7:0]            awaddr_q, rd_addr;
	logic [31:0]           wdata_q, rd_val;
	logic                  rd_hit;
	logic                  deep_sleep_q, sleep_pend_q;
	logic                  active_sel_q, switch_done_q;
	logic                  rc_stable_q, rc_stable_prev_q, xt_stable_q, xt_stable_prev_q;
	logic [3:0]            rc_cnt_q;
	logic [7:0]            xt_cnt_q;
	logic                  tally_arm_q, tally_run_q, tally_done_q;
	logic [15:0]           tally_q;
	logic [4:0]            fall_cnt_q;
	logic                  prim_tick, mul_tick, half_tick, src_tick, sys_tick;
	logic [12:0]           acc_q;
	logic [13:0]           acc_sum;
	logic                  mul_on, settled_q;
	logic [7:0]            lock_cnt_q;
	logic                  sys_ready_q, sys_wr;
	logic [N_PERIPH-1:0]   gate_q;

	// 3->divisor for the system prescaler; code 7 is divide by 3
	function automatic logic [7:0] master_divide_select_div(input logic [2:0] code);
		master_divide_select_div = (code == 3'h7) ? 8'h03 : 8'(8'h01 << code);
	endfunction : master_divide_select_div

	// oscillator pins are asynchronous; third stage only feeds edge detect
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_q <= 3'h0;
			sync2_q <= 3'h0;
			sync3_q <= 3'h0;
		end else begin
			sync1_q <= {xtal_osc_clock, rc_osc_clock, low_rate_clock};
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	assign slow_rise = sync2_q[0] & ~sync3_q[0];
	assign slow_fall = ~sync2_q[0] & sync3_q[0];
	assign rc_tick   = sync2_q[1] & ~sync3_q[1];
	assign xt_tick   = sync2_q[2] & ~sync3_q[2];

	// register bus: address and data taken independently, answered together
	assign s_axi_awready = ~aw_full_q;
	assign s_axi_wready  = ~w_full_q;
	assign wr_en         = aw_full_q & w_full_q & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;
	assign rd_en         = s_axi_arvalid & ~s_axi_rvalid;
	assign rd_addr       = s_axi_araddr;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q    <= 1'b0;
			w_full_q     <= 1'b0;
			awaddr_q     <= 8'h00;
			wdata_q      <= 32'h0000_0000;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= ccg_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && !aw_full_q) begin
				aw_full_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_full_q) begin
				w_full_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
			end
			if (wr_en) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (awaddr_q[1:0] != 2'h0 || awaddr_q > ccg_pkg::TICK_CAL_ADDR) ?
					ccg_pkg::RESP_SLVERR : ccg_pkg::RESP_OKAY;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_full_q    <= 1'b0;
				w_full_q     <= 1'b0;
			end
		end
	end

	always_comb begin
		rd_hit = 1'b1;
		rd_val = 32'h0000_0000;
		case (rd_addr)
			ccg_pkg::OSC_CTRL_ADDR:  rd_val = 32'(osc_q);
			ccg_pkg::FREQ_MEAS_ADDR: rd_val = {15'h0000, tally_done_q, tally_q};
			ccg_pkg::MUL_CFG_ADDR:   rd_val = 32'(mul_q);
			ccg_pkg::SYS_CLK_ADDR:   rd_val = 32'(sys_q);
			ccg_pkg::WAKE_MODE_ADDR: rd_val = 32'(deep_sleep_q) << ccg_pkg::DEEP_SLEEP_BIT;
			ccg_pkg::PGATE_EN_ADDR:  rd_val = 32'h0000_0000;
			ccg_pkg::PGATE_DIS_ADDR: rd_val = 32'h0000_0000;
			ccg_pkg::PGATE_ST_ADDR:  rd_val = 32'(gate_q); // see RULE22
			ccg_pkg::PWR_STAT_ADDR: begin
				rd_val[ccg_pkg::ST_XTAL_STABLE] = xt_stable_q;
				rd_val[ccg_pkg::ST_MUL_READY]   = settled_q;
				rd_val[ccg_pkg::ST_SYS_READY]   = sys_ready_q;
				rd_val[ccg_pkg::ST_SWITCH_DONE] = switch_done_q;
				rd_val[ccg_pkg::ST_RC_STABLE]   = rc_stable_q;
			end
			ccg_pkg::TICK_CAL_ADDR:  rd_val = ccg_pkg::TICK_CAL; // see RULE21
			default:                 rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= ccg_pkg::RESP_OKAY;
		end else if (rd_en) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_val;
			s_axi_rresp  <= rd_hit ? ccg_pkg::RESP_OKAY : ccg_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// configuration registers
	assign sys_wr = wr_en && awaddr_q == ccg_pkg::SYS_CLK_ADDR;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			osc_q        <= ccg_pkg::OSC_CTL_RST; // see RULE3
			mul_q        <= ccg_pkg::MUL_CFG_RST; // see RULE6
			sys_q        <= ccg_pkg::SYS_CFG_RST;
			deep_sleep_q <= 1'b0;
		end else begin
			if (wr_en && awaddr_q == ccg_pkg::OSC_CTRL_ADDR)
				osc_q <= ccg_pkg::ccg_osc_ctl_t'(wdata_q[11:0]);
			if (wait_mode_entry)
				osc_q.main_osc_select <= 1'b0; // see RULE3
			if (wr_en && awaddr_q == ccg_pkg::MUL_CFG_ADDR)
				mul_q <= ccg_pkg::ccg_mul_cfg_t'(wdata_q[26:0]);
			if (sys_wr)
				sys_q <= ccg_pkg::ccg_sys_cfg_t'(wdata_q[5:0]);
			if (wr_en && awaddr_q == ccg_pkg::WAKE_MODE_ADDR)
				deep_sleep_q <= wdata_q[ccg_pkg::DEEP_SLEEP_BIT];
		end
	end

	// peripheral gates, bit index is the peripheral identifier
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gate_q <= '0; // see RULE23
		end else if (wr_en && awaddr_q == ccg_pkg::PGATE_EN_ADDR) begin
			gate_q <= gate_q | wdata_q[N_PERIPH-1:0]; // see RULE22
		end else if (wr_en && awaddr_q == ccg_pkg::PGATE_DIS_ADDR) begin
			gate_q <= gate_q & ~wdata_q[N_PERIPH-1:0]; // see RULE22
		end
	end

	assign periph_clock = {N_PERIPH{sys_tick}} & gate_q; // see RULE23, see RULE24

	// fast RC settling after a frequency change
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rc_stable_q <= 1'b0;
			rc_cnt_q    <= ccg_pkg::RC_SETTLE;
		end else if (wr_en && awaddr_q == ccg_pkg::OSC_CTRL_ADDR
				&& wdata_q[3:2] != osc_q.rc_frequency_select) begin
			rc_stable_q <= 1'b0; // see RULE25
			rc_cnt_q    <= ccg_pkg::RC_SETTLE;
		end else if (!rc_stable_q && slow_rise) begin
			if (rc_cnt_q == 4'h0)
				rc_stable_q <= 1'b1; // see RULE25
			else
				rc_cnt_q <= rc_cnt_q - 4'h1;
		end
	end

	// crystal startup count on slow clock divided by eight
	ccg_tick_div #(.W(8)) u_xt_prediv (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.tick_in  (slow_rise),
		.restart  (1'b0),
		.divisor  (ccg_pkg::XTAL_PREDIV),
		.tick_out (xt8_tick)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			xt_stable_q <= 1'b0;
			xt_cnt_q    <= 8'h00;
		end else if (wr_en && awaddr_q == ccg_pkg::OSC_CTRL_ADDR) begin
			xt_stable_q <= 1'b0; // see RULE26
			xt_cnt_q    <= wdata_q[11:4];
		end else if (!osc_q.crystal_enable) begin
			xt_stable_q <= 1'b0;
		end else if (!xt_stable_q && xt_cnt_q == 8'h00) begin
			xt_stable_q <= 1'b1; // see RULE26
		end else if (!xt_stable_q && xt8_tick) begin
			xt_cnt_q <= xt_cnt_q - 8'h01; // see RULE26
		end
	end

	// hand over only on an edge of the new source so no runt pulse escapes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			active_sel_q  <= 1'b0;
			switch_done_q <= 1'b1;
		end else if (osc_q.main_osc_select != active_sel_q) begin
			switch_done_q <= 1'b0;
			if (osc_q.main_osc_select ? xt_tick : rc_tick) begin
				active_sel_q  <= osc_q.main_osc_select; // see RULE1
				switch_done_q <= 1'b1; // see RULE2
			end
		end
	end

	// primary stays stopped while its oscillator is unsettled
	assign prim_tick = active_sel_q ? (xt_tick & xt_stable_q) : (rc_tick & rc_stable_q); // see RULE25

	// frequency tally from a slow rising edge to the sixteenth slow falling edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rc_stable_prev_q <= 1'b0;
			xt_stable_prev_q <= 1'b0;
			tally_arm_q      <= 1'b0;
			tally_run_q      <= 1'b0;
			tally_done_q     <= 1'b0;
			tally_q          <= 16'h0000;
			fall_cnt_q       <= 5'h00;
		end else begin
			rc_stable_prev_q <= rc_stable_q;
			xt_stable_prev_q <= xt_stable_q;
			if ((!active_sel_q && rc_stable_q && !rc_stable_prev_q)
					|| (active_sel_q && xt_stable_q && !xt_stable_prev_q)
					|| (osc_q.main_osc_select != active_sel_q && switch_done_q == 1'b0
					&& (osc_q.main_osc_select ? xt_tick : rc_tick)))
				tally_arm_q <= 1'b1; // see RULE4
			if (tally_arm_q && slow_rise) begin
				tally_arm_q  <= 1'b0;
				tally_run_q  <= 1'b1; // see RULE4
				tally_done_q <= 1'b0;
				tally_q      <= 16'h0000;
				fall_cnt_q   <= 5'h00;
			end else if (tally_run_q) begin
				if (prim_tick)
					tally_q <= tally_q + 16'h0001;
				if (slow_fall) begin
					fall_cnt_q <= fall_cnt_q + 5'h01;
					if (fall_cnt_q + 5'h01 == ccg_pkg::TALLY_FALLS) begin
						tally_run_q  <= 1'b0; // see RULE5
						tally_done_q <= 1'b1;
					end
				end
			end
		end
	end

	// multiplier as a rate accumulator; output is capped at one tick per cycle
	assign mul_on  = mul_q.feedback_factor != 11'h000 && mul_q.input_prescale_value != 8'h00; // see RULE6, see RULE8
	assign acc_sum = {1'b0, acc_q} + (prim_tick && acc_q[12] == 1'b0 ? 14'(mul_q.feedback_factor) + 14'h0001 : 14'h0000);

	always_ff @(posedge aclk) begin
		if (!aresetn || !mul_on) begin
			acc_q    <= 13'h0000;
			mul_tick <= 1'b0;
		end else if (acc_sum >= 14'(mul_q.input_prescale_value)) begin
			acc_q    <= 13'(acc_sum - 14'(mul_q.input_prescale_value)); // see RULE7
			mul_tick <= 1'b1;
		end else begin
			acc_q    <= acc_sum[12:0];
			mul_tick <= 1'b0;
		end
	end

	// lock countdown on the slow clock
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			settled_q  <= 1'b0;
			lock_cnt_q <= 8'h00;
		end else if (wr_en && awaddr_q == ccg_pkg::MUL_CFG_ADDR
				&& (wdata_q[26:16] != mul_q.feedback_factor || wdata_q[7:0] != mul_q.input_prescale_value)) begin
			settled_q  <= 1'b0; // see RULE9
			lock_cnt_q <= wdata_q[15:8];
		end else if (!mul_on) begin
			settled_q <= 1'b0;
		end else if (!settled_q && lock_cnt_q == 8'h00) begin
			settled_q <= 1'b1; // see RULE10
		end else if (!settled_q && slow_rise) begin
			lock_cnt_q <= lock_cnt_q - 8'h01; // see RULE10
		end
	end

	ccg_tick_div #(.W(8)) u_halve (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.tick_in  (mul_tick),
		.restart  (1'b0),
		.divisor  (ccg_pkg::HALVE_DIV),
		.tick_out (half_tick)
	);

	// system clock source and prescaler
	always_comb begin
		case (sys_q.master_source_select)
			ccg_pkg::SRC_SLOW:    src_tick = slow_rise; // see RULE15
			ccg_pkg::SRC_PRIMARY: src_tick = prim_tick;
			default:              src_tick = sys_q.halve_multiplied_clock ? half_tick : mul_tick; // see RULE12
		endcase
	end

	ccg_tick_div #(.W(8)) u_sys_master_divide_select (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.tick_in  (src_tick),
		.restart  (sys_wr),
		.divisor  (master_divide_select_div(sys_q.master_divide_select)), // see RULE16
		.tick_out (sys_tick)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn)
			sys_ready_q <= 1'b1;
		else if (sys_wr)
			sys_ready_q <= 1'b0; // see RULE17
		else if (sys_tick)
			sys_ready_q <= 1'b1; // see RULE17
	end

	// core clock sleep control; wake wins over a sleep request in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			core_q       <= CORE_RUN; // see RULE19
			sleep_pend_q <= 1'b0;
		end else begin
			sleep_pend_q <= 1'b0;
			case (core_q)
				CORE_RUN:
					if (sleep_request && !deep_sleep_q && !wake_irq)
						core_q <= instr_done ? CORE_STOP : CORE_DRAIN; // see RULE18, see RULE20
				CORE_DRAIN:
					if (wake_irq)
						core_q <= CORE_RUN;
					else if (instr_done)
						core_q <= CORE_STOP; // see RULE20
				CORE_STOP:
					if (wake_irq)
						core_q <= CORE_RUN; // see RULE19
				default:
					core_q <= CORE_RUN;
			endcase
		end
	end

	assign core_clock_on    = core_q != CORE_STOP;
	assign core_clock       = sys_tick & core_clock_on;
	assign free_core_clock  = sys_tick;
	assign system_clock     = sys_tick;
	assign primary_clock    = prim_tick;
	assign multiplied_clock = mul_tick;
endmodule : ccg_top

// ==== bench/ccg_core_model.sv ====
// processor side: issues a wait-for-interrupt, retires the instruction late
module ccg_core_model (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic sleep_cmd,
	input  wire logic core_clock,
	output logic      sleep_request = 1'b0,
	output logic      instr_done = 1'b0,
	output int        core_ticks
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [1:0] busy_q = 2'h0;
	always @(posedge aclk) begin
		if (!aresetn) begin
			sleep_request <= 1'b0;
			busy_q <= 2'h0;
			instr_done <= 1'b0;
		end else begin
			sleep_request <= sleep_cmd;
			busy_q <= {busy_q[0], sleep_request};
			// instruction in flight finishes three cycles after the request, so gating must wait
			instr_done <= busy_q[1];
		end
	end
	always @(negedge aclk) core_ticks <= core_ticks + int'(core_clock);
endmodule : ccg_core_model

// ==== bench/ccg_checker.sv ====
module ccg_checker #(
	parameter int N_PERIPH = 32
) (
	input wire logic                aclk,
	input wire logic                aresetn,
	input wire logic [7:0]          s_axi_awaddr,
	input wire logic                s_axi_awvalid,
	input wire logic                s_axi_awready,
	input wire logic [1:0]          s_axi_bresp,
	input wire logic                s_axi_bvalid,
	input wire logic                s_axi_bready,
	input wire logic [7:0]          s_axi_araddr,
	input wire logic                s_axi_arvalid,
	input wire logic                s_axi_arready,
	input wire logic [31:0]         s_axi_rdata,
	input wire logic                s_axi_rvalid,
	input wire logic                instr_done,
	input wire logic                wake_irq,
	input wire logic                multiplied_clock,
	input wire logic                system_clock,
	input wire logic                core_clock,
	input wire logic                core_clock_on,
	input wire logic [N_PERIPH-1:0] periph_clock
);
	logic       mul_wr_q;
	logic [7:0] ar_q;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	always_ff @(posedge aclk) begin
		if (!aresetn)
			mul_wr_q <= 1'b0;
		else if (s_axi_awvalid && s_axi_awready && s_axi_awaddr == ccg_pkg::MUL_CFG_ADDR)
			mul_wr_q <= 1'b1;
	end
	always_ff @(posedge aclk) begin
		if (s_axi_arvalid && s_axi_arready)
			ar_q <= s_axi_araddr;
	end
	chk_core_gate: assert property (core_clock == (system_clock && core_clock_on))
		else $error("core tick disagrees with run state");
	chk_wake_restart: assert property (wake_irq && !core_clock_on |=> core_clock_on)
		else $error("core clock not restarted by interrupt");
	chk_sleep_hold: assert property (!core_clock_on && !wake_irq |=> !core_clock_on)
		else $error("core clock restarted without interrupt");
	chk_gate_after_instr: assert property ($fell(core_clock_on) |-> $past(instr_done) || $past(instr_done, 2))
		else $error("core clock stopped before instruction finished");
	chk_gates_reset: assert property ($rose(aresetn) |-> periph_clock == '0)
		else $error("peripheral clock running after reset");
	chk_periph_source: assert property (periph_clock != '0 |-> system_clock)
		else $error("peripheral tick without system tick");
	chk_mul_idle: assert property (!mul_wr_q |-> !multiplied_clock)
		else $error("multiplied clock runs with zero prescale");
	chk_tick_cal: assert property (s_axi_rvalid && ar_q == ccg_pkg::TICK_CAL_ADDR |-> s_axi_rdata == ccg_pkg::TICK_CAL)
		else $error("tick calibration value wrong");
	chk_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	cover property ($fell(core_clock_on));
	cover property (periph_clock != '0);
	cover property (multiplied_clock);
endmodule : ccg_checker
bind ccg_top ccg_checker #(.N_PERIPH(N_PERIPH)) chk_u (.*);

// ==== bench/ccg_top_tb_top.sv ====
module ccg_top_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic aclk = '0, aresetn = '0, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
	logic s_axi_arvalid = '0, s_axi_rready = '0, low_rate_clock = '0, rc_osc_clock = '0, xtal_osc_clock = '0;
	logic wait_mode_entry = '0, wake_irq = '0, sleep_cmd = '0, sleep_request, instr_done;
	logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, periph_clock, v;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic primary_clock, multiplied_clock, system_clock, free_core_clock, core_clock, core_clock_on;
	int err_count = 0, tests_run = 0, np = 0, cm = 0, ns = 0, n0 = 0, n2 = 0;
	int core_ticks, t, a0, a2;
	int dv[8] = '{1, 2, 4, 8, 16, 32, 64, 3};
	ccg_top dut_u (.*);
	ccg_core_model core_u (.*);
	always #12.5 aclk = ~aclk;
	always #400 low_rate_clock = ~low_rate_clock;
	always #50 rc_osc_clock = ~rc_osc_clock;
	always #75 xtal_osc_clock = ~xtal_osc_clock;
	always @(negedge aclk) begin
		np += primary_clock;
		cm += multiplied_clock;
		ns += system_clock;
		n0 += periph_clock[0];
		n2 += periph_clock[2];
	end
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : give_verdict
	task automatic axw(logic [7:0] a, logic [31:0] d, logic [1:0] er = ccg_pkg::RESP_OKAY);
		logic aw = 1, w = 1, b = 0;
		int n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!b && n < 300) begin
			@(posedge aclk);
			b = s_axi_bvalid;
			r = s_axi_bresp;
			if (s_axi_awready) aw = 0;
			if (s_axi_wready) w = 0;
			s_axi_awvalid <= aw;
			s_axi_wvalid <= w;
			n++;
		end
		s_axi_bready <= 1'b0;
		check("wr_resp", {b, r}, {1'b1, er});
	endtask : axw
	task automatic axr(logic [7:0] a, logic [1:0] er = ccg_pkg::RESP_OKAY);
		logic ar = 1, b = 0;
		int n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!b && n < 300) begin
			@(posedge aclk);
			b = s_axi_rvalid;
			v = s_axi_rdata;
			r = s_axi_rresp;
			if (s_axi_arready) ar = 0;
			s_axi_arvalid <= ar;
			n++;
		end
		s_axi_rready <= 1'b0;
		check("rd_resp", {b, r}, {1'b1, er});
	endtask : axr
	task automatic poll(logic [7:0] a, int bn, logic e);
		int n = 0;
		do begin
			axr(a);
			n++;
		end while (v[bn] !== e && n < 500);
		check("poll", v[bn], e);
	endtask : poll
	// counts system ticks while the reference source gives n ticks
	task automatic meas(logic use_m, int n, output int got);
		int r0, s0, k;
		r0 = use_m ? cm : np;
		s0 = ns;
		k = 0;
		while ((use_m ? cm : np) - r0 < n && k < 30000) begin
			@(posedge aclk);
			k++;
		end
		got = ns - s0;
	endtask : meas
	initial begin
		repeat (60000) @(posedge aclk);
		err_count++;
		give_verdict;
	end
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		axr(ccg_pkg::PWR_STAT_ADDR);
		check("status_rst", v & 32'h0003_000B, 32'h0001_0008);
		axr(ccg_pkg::OSC_CTRL_ADDR);
		check("osc_rst", v, 32'h0);
		axr(ccg_pkg::TICK_CAL_ADDR);
		check("tick_cal", v, 32'h0000_1770);
		axr(ccg_pkg::PGATE_ST_ADDR);
		check("gate_rst", v, 32'h0);
		axr(8'h28, ccg_pkg::RESP_SLVERR);
		axr(8'h02, ccg_pkg::RESP_SLVERR);
		axw(8'h2C, 32'h1, ccg_pkg::RESP_SLVERR);
		axw(ccg_pkg::PGATE_EN_ADDR, 32'h5);
		axw(ccg_pkg::PGATE_ST_ADDR, 32'hFF);
		axr(ccg_pkg::PGATE_ST_ADDR);
		check("gate_on", v, 32'h5);
		axw(ccg_pkg::PGATE_DIS_ADDR, 32'h1);
		axr(ccg_pkg::PGATE_ST_ADDR);
		check("gate_off", v, 32'h4);
		a0 = n0;
		a2 = n2;
		meas(0, 64, t);
		check("p0_ticks", n0 - a0, 0);
		check("p2_ticks", n2 - a2, t);
		poll(ccg_pkg::PWR_STAT_ADDR, ccg_pkg::ST_RC_STABLE, 1);
		poll(ccg_pkg::FREQ_MEAS_ADDR, ccg_pkg::TALLY_DONE_BIT, 1);
		check("tally_rc", v[15:0] >= 122 && v[15:0] <= 130, 1);
		axw(ccg_pkg::OSC_CTRL_ADDR, 32'h23);
		poll(ccg_pkg::PWR_STAT_ADDR, ccg_pkg::ST_XTAL_STABLE, 1);
		poll(ccg_pkg::PWR_STAT_ADDR, ccg_pkg::ST_SWITCH_DONE, 1);
		repeat (1280) @(posedge aclk);
		axr(ccg_pkg::FREQ_MEAS_ADDR);
		check("tally_xt", v[16] && v[15:0] >= 80 && v[15:0] <= 88, 1);
		wait_mode_entry <= 1'b1;
		@(posedge aclk);
		wait_mode_entry <= 1'b0;
		axr(ccg_pkg::OSC_CTRL_ADDR);
		check("osc_wait", v[0], 0);
		poll(ccg_pkg::PWR_STAT_ADDR, ccg_pkg::ST_SWITCH_DONE, 1);
		axw(ccg_pkg::MUL_CFG_ADDR, 32'h0001_0301);
		axr(ccg_pkg::PWR_STAT_ADDR);
		check("settle_clr", v[ccg_pkg::ST_MUL_READY], 0);
		poll(ccg_pkg::PWR_STAT_ADDR, ccg_pkg::ST_MUL_READY, 1);
		a0 = cm;
		meas(0, 96, t);
		check("mul_rate", cm - a0 >= 188 && cm - a0 <= 196, 1);
		for (int i = 0; i < 8; i++) begin
			axw(ccg_pkg::SYS_CLK_ADDR, {i[2:0], 2'b01});
			poll(ccg_pkg::PWR_STAT_ADDR, ccg_pkg::ST_SYS_READY, 1);
			meas(0, 192, t);
			check("sys_div", t >= 192 / dv[i] - 1 && t <= 192 / dv[i] + 1, 1);
		end
		axw(ccg_pkg::SYS_CLK_ADDR, 32'h22);
		poll(ccg_pkg::PWR_STAT_ADDR, ccg_pkg::ST_SYS_READY, 1);
		meas(1, 192, t);
		check("sys_halve", t >= 94 && t <= 98, 1);
		axw(ccg_pkg::SYS_CLK_ADDR, 32'h18);
		axr(ccg_pkg::PWR_STAT_ADDR);
		check("sys_busy", v[ccg_pkg::ST_SYS_READY], 0);
		axw(ccg_pkg::SYS_CLK_ADDR, 32'h01);
		poll(ccg_pkg::PWR_STAT_ADDR, ccg_pkg::ST_SYS_READY, 1);
		axw(ccg_pkg::MUL_CFG_ADDR, 32'h0000_0301);
		repeat (20) @(posedge aclk);
		a0 = cm;
		repeat (200) @(posedge aclk);
		check("mul_off", cm - a0, 0);
		sleep_cmd <= 1'b1;
		@(posedge aclk);
		sleep_cmd <= 1'b0;
		repeat (8) @(posedge aclk);
		a0 = core_ticks;
		a2 = n2;
		repeat (200) @(posedge aclk);
		@(negedge aclk);
		check("asleep", core_clock_on, 0);
		check("core_idle", core_ticks - a0, 0);
		check("p2_run", n2 - a2 >= 48 && n2 - a2 <= 52, 1);
		@(posedge aclk);
		wake_irq <= 1'b1;
		@(posedge aclk);
		@(negedge aclk);
		check("woken", core_clock_on, 1);
		@(posedge aclk);
		wake_irq <= 1'b0;
		axw(ccg_pkg::WAKE_MODE_ADDR, 32'h0010_0000);
		sleep_cmd <= 1'b1;
		@(posedge aclk);
		sleep_cmd <= 1'b0;
		repeat (8) @(posedge aclk);
		@(negedge aclk);
		check("deep_sel", core_clock_on, 1);
		give_verdict;
	end
endmodule : ccg_top_tb_top
